/* verilog/cfsd_top.v */
// channel error flags, thermal latches, sense mux and bypass monitor
// assumes analog fault and comparator levels arrive as pins and the
// channel on commands come from logic on CLOCK
//
// Functional notes
// (RL1) config command bit 0 set clears thermal latches
// (RL2) error flag is thermal flag or overload
// (RL3) error flags hold until shifted out
// (RL4) overload part cleared at second frame edge
// (RL5) thermal latch forces gate off until cleared
// (RL6) thermal state also held in error flag
// (RL7) after clear, flag cleared until third edge
// (RL8) first diagnosis after clear still shows failure
// (RL9) persisting overload sets flag right after clear
// (RL10) limit, short, dynamic, thermal flag; others not
// (RL11) select field routes one channel to sense
// (RL12) off code and non-channel codes disable sense output
// (RL13) faulted selected channel has sense switched off
// (RL14) channels 0 to 2 take load type ratio
// (RL15) bypass comparator of selected channel readable
// (RL16) load type bit: 0 bulb, 1 led
// (RL17) dynamic shutdown flag re-sets while still active
// (RL18) off code is a parameter; select encoding is fixed
`timescale 1ns/1ps
`include "cfsd_defs.vh"
module cfsd_top #(
    parameter [2:0] MUX_OFF_CODE = `CFSD_MUX_OFF
) (
    input wire CLOCK,              // 10 MHz block clock
    input wire RST,                // synchronous reset, active high
    input wire SCLK,               // serial clock pin
    input wire CS_N,               // chip select pin, active low
    input wire MOSI,               // serial data in pin
    output wire MISO,              // serial data out pin
    output wire MISO_OE,           // miso driver enable
    input wire [5:0] CH_ON,        // channel_on_bit per channel
    input wire [5:0] CH_OVERLOAD,  // current limit or short to ground
    input wire [5:0] CH_DYN_SHUT,  // dynamic temperature shutdown
    input wire [5:0] CH_OVERTEMP,  // thermal shutdown sensor
    input wire [5:0] BYPASS_CMP,   // vds comparator, 1 near ground
    output wire [5:0] GATE_EN,     // gate enable per channel
    output wire [5:0] ERR_FLAG,    // channel_error_flag per channel
    output wire [5:0] THERM_LATCH, // gate-control thermal latches
    output wire [2:0] SENSE_SEL,   // sense_channel_select
    output wire SENSE_EN,          // sense_output_pin enable
    output wire [2:0] LOAD_TYPE,   // load_type_bit, channels 2..0
    output wire BYPASS_RESULT      // bypass_monitor_result
);
    // picks one channel bit; non-channel codes give zero
    function chan_bit;
        input [5:0] vec;
        input [2:0] sel;
        begin
            if (sel < 3'h6) begin
                chan_bit = vec[sel];
            end else begin
                chan_bit = 1'b0;
            end
        end
    endfunction

    // true where the select code names a real channel
    function chan_valid;
        input [2:0] sel;
        begin
            chan_valid = (sel < 3'h6) && (sel != MUX_OFF_CODE);
        end
    endfunction

    wire [`CFSD_SYNC_W-1:0] pins_raw;
    wire [`CFSD_SYNC_W-1:0] pins_s;
    wire sclk_s;
    wire cs_n_s;
    wire mosi_s;
    wire [5:0] ovl_s;
    wire [5:0] dyn_s;
    wire [5:0] temp_s;
    wire [5:0] byp_s;

    // chip select passes inverted so that the cleared synchroniser reads
    // as deselected; otherwise a phantom frame would open after reset
    assign pins_raw[0] = MOSI;
    assign pins_raw[1] = ~CS_N;
    assign pins_raw[2] = SCLK;
    assign pins_raw[8:3] = CH_OVERLOAD;
    assign pins_raw[14:9] = CH_DYN_SHUT;
    assign pins_raw[20:15] = CH_OVERTEMP;
    assign pins_raw[26:21] = BYPASS_CMP;
    assign mosi_s = pins_s[0];
    assign cs_n_s = ~pins_s[1];
    assign sclk_s = pins_s[2];
    assign ovl_s = pins_s[8:3];
    assign dyn_s = pins_s[14:9];
    assign temp_s = pins_s[20:15];
    assign byp_s = pins_s[26:21];

    // one shared stage set: every pin is a slow level except the serial
    // clock, whose phases the host keeps at two clock periods or more
    cfsd_sync #(
        .W(`CFSD_SYNC_W)
    ) u_sync (
        .CLOCK(CLOCK),
        .RST(RST),
        .d(pins_raw),
        .q(pins_s)
    );

    wire frame_start;
    wire frame_done;
    wire in_frame;
    wire rise_p;
    wire [1:0] rise_num;
    wire [7:0] rx_byte;
    reg [7:0] tx_word;

    cfsd_spi_frame u_frame (
        .CLOCK(CLOCK),
        .RST(RST),
        .sclk(sclk_s),
        .cs_n(cs_n_s),
        .mosi(mosi_s),
        .tx_word(tx_word),
        .frame_start(frame_start),
        .frame_done(frame_done),
        .in_frame(in_frame),
        .rise_p(rise_p),
        .rise_num(rise_num),
        .rx_byte(rx_byte),
        .miso(MISO),
        .miso_oe(MISO_OE)
    );

    // state
    reg [2:0] mux_r;
    reg [2:0] mux_nxt;
    reg [2:0] load_r;
    reg [2:0] load_nxt;
    reg [1:0] rd_sel_r;
    reg [1:0] rd_sel_nxt;
    reg diag_frame_r;
    reg diag_frame_nxt;
    reg [5:0] ovl_r;
    reg [5:0] ovl_nxt;
    reg [5:0] tflag_r;
    reg [5:0] tflag_nxt;
    reg [5:0] tlatch_r;
    reg [5:0] tlatch_nxt;
    reg ctl_pend_r;
    reg ctl_pend_nxt;
    reg [5:0] gate_r;
    reg [5:0] err_r;
    reg sense_en_r;
    reg sbm_r;

    wire [2:0] opcode = rx_byte[`CFSD_OP_HI:`CFSD_OP_LO];
    // command header decode; opcodes 0xx match none and are ignored
    wire op_read = (opcode == `CFSD_OP_READ);
    wire op_load_cfg = (opcode == `CFSD_OP_LOAD_CFG);
    wire op_hw_cfg = (opcode == `CFSD_OP_HW_CONFIG);
    wire op_diag_ctl = (opcode == `CFSD_OP_DIAG_CTL);
    // the reset bit of the config command is not acted on here
    wire ctl_cmd = frame_done && op_hw_cfg && rx_byte[`CFSD_CTL_BIT]; // RL1
    wire [5:0] ovl_set = ovl_s | dyn_s; // RL10 RL17
    wire ovl_clr = diag_frame_r && rise_p && (rise_num == `CFSD_CLR_EDGE); // RL4
    // thermal flag clear window spans frame start to its third edge
    wire tflag_block = ctl_pend_r && in_frame; // RL7
    wire ctl_done = ctl_pend_r && rise_p && (rise_num == `CFSD_RELATCH_EDGE);
    wire [5:0] err_now = tflag_r | ovl_r; // RL2
    wire [5:0] sense_fault = ovl_set | tlatch_r;
    // selected channel view, shared by sense enable and bypass bit
    wire sel_valid = chan_valid(mux_r); // RL18
    wire sel_fault = chan_bit(sense_fault, mux_r); // RL13
    wire sel_bypass = chan_bit(byp_s, mux_r); // RL15

    // next-state logic for command registers
    always @* begin
        mux_nxt = mux_r;
        load_nxt = load_r;
        rd_sel_nxt = rd_sel_r;
        diag_frame_nxt = diag_frame_r;
        if (frame_start) begin
            diag_frame_nxt = (rd_sel_r == `CFSD_RD_DIAG);
            // a read request answers in the one frame after it only
            rd_sel_nxt = `CFSD_RD_DIAG;
        end
        if (frame_done) begin
            if (op_diag_ctl) begin
                mux_nxt = rx_byte[2:0]; // RL11 RL12
            end else if (op_load_cfg) begin
                load_nxt = rx_byte[2:0]; // RL14 RL16
            end else if (op_read) begin
                rd_sel_nxt = rx_byte[1:0];
            end
        end
    end

    // overload part of the flags: set wins, a live overload re-flags at once
    always @* begin
        ovl_nxt = ovl_r; // RL3
        if (ovl_clr) begin
            ovl_nxt = 6'h00;
        end
        ovl_nxt = ovl_nxt | ovl_set; // RL9 RL17
    end

    // gate latch holds in off state as well; set wins over the clear
    always @* begin
        tlatch_nxt = tlatch_r; // RL5
        if (ctl_cmd) begin
            tlatch_nxt = 6'h00; // RL1
        end
        tlatch_nxt = tlatch_nxt | temp_s; // RL5
    end

    // second copy of the thermal state; clear wins in its window, so a
    // channel still hot after the clear re-flags only past the third edge
    always @* begin
        if (tflag_block) begin
            tflag_nxt = 6'h00; // RL7
        end else begin
            tflag_nxt = tflag_r | temp_s; // RL6
        end
    end

    // pending clear, armed by the command and spent in the next frame
    always @* begin
        ctl_pend_nxt = ctl_pend_r;
        if (ctl_done) begin
            ctl_pend_nxt = 1'b0; // RL7
        end
        if (ctl_cmd) begin
            ctl_pend_nxt = 1'b1;
        end
    end

    // word loaded at frame start, before the clear window opens, so the
    // frame after a clear still carries the old thermal failure
    wire [7:0] diag_word = {1'b0, sbm_r, err_now}; // RL8
    wire [7:0] sel_word = {5'h00, mux_r};
    wire [7:0] load_word = {5'h00, load_r};
    // selectors 0 and 3 answer with the diagnosis word
    always @* begin
        if (rd_sel_r == `CFSD_RD_DIAG_CTL) begin
            tx_word = sel_word;
        end else if (rd_sel_r == `CFSD_RD_LOAD_CFG) begin
            tx_word = load_word;
        end else begin
            tx_word = diag_word; // RL8
        end
    end

    // command registers
    always @(posedge CLOCK) begin
        if (RST) begin
            mux_r <= `CFSD_MUX_RESET;
            load_r <= `CFSD_LOAD_RESET;
            rd_sel_r <= `CFSD_RD_DIAG;
            diag_frame_r <= 1'b0;
        end else begin
            mux_r <= mux_nxt;
            load_r <= load_nxt;
            rd_sel_r <= rd_sel_nxt;
            diag_frame_r <= diag_frame_nxt;
        end
    end

    // flags and latches
    always @(posedge CLOCK) begin
        if (RST) begin
            ovl_r <= 6'h00;
            tflag_r <= 6'h00;
            tlatch_r <= 6'h00;
            ctl_pend_r <= 1'b0;
        end else begin
            ovl_r <= ovl_nxt;
            tflag_r <= tflag_nxt;
            tlatch_r <= tlatch_nxt;
            ctl_pend_r <= ctl_pend_nxt;
        end
    end

    // output copies; gate and flag lag the latches by one cycle
    always @(posedge CLOCK) begin
        if (RST) begin
            gate_r <= 6'h00;
            err_r <= 6'h00;
            sense_en_r <= 1'b0;
            sbm_r <= 1'b0;
        end else begin
            gate_r <= CH_ON & ~tlatch_r; // RL5
            err_r <= err_now; // RL2
            // sense off for a disable code or a faulted channel
            sense_en_r <= sel_valid && !sel_fault; // RL12 RL13 RL18
            // no channel selected gives a zero bit
            sbm_r <= sel_valid && sel_bypass; // RL15
        end
    end

    assign GATE_EN = gate_r;
    assign ERR_FLAG = err_r;
    assign THERM_LATCH = tlatch_r;
    assign SENSE_SEL = mux_r; // RL11
    assign SENSE_EN = sense_en_r;
    assign LOAD_TYPE = load_r; // RL14
    assign BYPASS_RESULT = sbm_r;
endmodule // cfsd_top

/* inc/cfsd_defs.vh */
// constants for the channel diagnosis flag block
// assumes an 8-bit spi frame, msb first, six power channels
`ifndef CFSD_DEFS_VH
`define CFSD_DEFS_VH

`define CFSD_NCH 6
`define CFSD_SYNC_W 27

// command header, bits 7..5 of a received frame
`define CFSD_OP_HI 7
`define CFSD_OP_LO 5
`define CFSD_OP_READ 3'h4
`define CFSD_OP_LOAD_CFG 3'h5
`define CFSD_OP_HW_CONFIG 3'h6
`define CFSD_OP_DIAG_CTL 3'h7

// hardware_config_command fields
`define CFSD_CTL_BIT 0
`define CFSD_SWRST_BIT 1

// read selector, bits 1..0 of a read request
`define CFSD_RD_DIAG 2'h0
`define CFSD_RD_DIAG_CTL 2'h1
`define CFSD_RD_LOAD_CFG 2'h2

// diagnosis word layout
`define CFSD_DIAG_SBM_BIT 6

// reset values
`define CFSD_MUX_OFF 3'h6
`define CFSD_MUX_RESET 3'h6
`define CFSD_LOAD_RESET 3'h0

// rising sclk edges of a frame that mark the flag windows
`define CFSD_CLR_EDGE 2'h2
`define CFSD_RELATCH_EDGE 2'h3

`endif

/* verilog/cfsd_sync.v */
// three-stage synchroniser for a bus of independent pin levels
// assumes each bit is a slow level; no bus coherence is promised
`timescale 1ns/1ps
module cfsd_sync #(
    parameter W = 27
) (
    input wire CLOCK,         // block clock
    input wire RST,           // synchronous reset, active high
    input wire [W-1:0] d,     // raw pin levels
    output wire [W-1:0] q     // filtered levels
);
    reg [W-1:0] s1_r;
    reg [W-1:0] s2_r;
    reg [W-1:0] s3_r;
    reg [W-1:0] q_r;
    integer i;

    always @(posedge CLOCK) begin
        if (RST) begin
            s1_r <= {W{1'b0}};
            s2_r <= {W{1'b0}};
            s3_r <= {W{1'b0}};
            q_r <= {W{1'b0}};
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // a change counts only once stages two and three agree
            for (i = 0; i < W; i = i + 1) begin
                if (s2_r[i] == s3_r[i]) begin
                    q_r[i] <= s3_r[i];
                end
            end
        end
    end

    assign q = q_r;
endmodule // cfsd_sync

/* verilog/cfsd_spi_frame.v */
// 8-bit spi slave framer: edge detection, shifting, rise numbering
// assumes sclk idles low, data taken on rising and driven on falling edge
`timescale 1ns/1ps
module cfsd_spi_frame (
    input wire CLOCK,          // block clock
    input wire RST,            // synchronous reset, active high
    input wire sclk,           // synchronised serial clock
    input wire cs_n,           // synchronised chip select, active low
    input wire mosi,           // synchronised serial data in
    input wire [7:0] tx_word,  // word sent in the next frame
    output reg frame_start,    // pulse, chip select fell
    output reg frame_done,     // pulse, frame ended on a byte boundary
    output reg in_frame,       // level, chip select is low
    output reg rise_p,         // pulse, a rising sclk edge was taken
    output reg [1:0] rise_num, // rising edge number in frame, stops at 3
    output reg [7:0] rx_byte,  // last eight bits received
    output wire miso,          // serial data out
    output reg miso_oe         // high while miso is driven
);
    reg sclk_d_r;
    reg cs_d_r;
    reg [2:0] bit_cnt_r;
    reg got_r;
    reg [7:0] tx_r;
    wire start_w = cs_d_r & ~cs_n;
    wire end_w = ~cs_d_r & cs_n;
    wire rise_w = ~cs_n & ~sclk_d_r & sclk;
    wire fall_w = ~cs_n & sclk_d_r & ~sclk;

    always @(posedge CLOCK) begin
        if (RST) begin
            sclk_d_r <= 1'b0;
            cs_d_r <= 1'b1;
            bit_cnt_r <= 3'h0;
            got_r <= 1'b0;
            tx_r <= 8'h00;
            frame_start <= 1'b0;
            frame_done <= 1'b0;
            in_frame <= 1'b0;
            rise_p <= 1'b0;
            rise_num <= 2'h0;
            rx_byte <= 8'h00;
            miso_oe <= 1'b0;
        end else begin
            sclk_d_r <= sclk;
            cs_d_r <= cs_n;
            frame_start <= start_w;
            // frames that are not whole bytes are dropped
            frame_done <= end_w & got_r & (bit_cnt_r == 3'h0);
            in_frame <= ~cs_n;
            miso_oe <= ~cs_n;
            rise_p <= rise_w;
            if (start_w) begin
                bit_cnt_r <= 3'h0;
                got_r <= 1'b0;
                rise_num <= 2'h0;
                tx_r <= tx_word;
            end else begin
                if (rise_w) begin
                    rx_byte <= {rx_byte[6:0], mosi};
                    bit_cnt_r <= bit_cnt_r + 3'h1;
                    if (bit_cnt_r == 3'h7) begin
                        got_r <= 1'b1;
                    end
                    if (rise_num != 2'h3) begin
                        rise_num <= rise_num + 2'h1;
                    end
                end
                // daisy chain: received bits follow the own word out
                if (fall_w) begin
                    tx_r <= {tx_r[6:0], rx_byte[0]};
                end
            end
        end
    end

    assign miso = tx_r[7];
endmodule // cfsd_spi_frame

/* tb/cfsd_top_properties.sv */
// checker for the channel flag block, sees top ports only
// assumes a bind from the bench top file
`timescale 1ns/1ps
module cfsd_top_props #(
    parameter [2:0] MUX_OFF_CODE = 3'h6
) (
    input wire CLOCK, // clock
    input wire RST, // reset
    input wire CS_N, // select
    input wire MISO_OE, // miso enable
    input wire [5:0] CH_OVERLOAD, // overload
    input wire [5:0] CH_DYN_SHUT, // dyn shutdown
    input wire [5:0] CH_OVERTEMP, // thermal
    input wire [5:0] BYPASS_CMP, // comparators
    input wire [5:0] GATE_EN, // gates
    input wire [5:0] ERR_FLAG, // flags
    input wire [5:0] THERM_LATCH, // latches
    input wire [2:0] SENSE_SEL, // select
    input wire SENSE_EN, // sense on
    input wire BYPASS_RESULT // bypass bit
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    wire [5:0] fault = CH_OVERLOAD | CH_DYN_SHUT;
    wire sel_ok = (SENSE_SEL < 3'h6) && (SENSE_SEL != MUX_OFF_CODE);
    wire [5:0] sel_hit = sel_ok ? (6'h01 << SENSE_SEL) : 6'h00;
    wire sel_bad = |(sel_hit & (CH_OVERLOAD | CH_OVERTEMP));
    wire sel_quiet = sel_ok && ~|(sel_hit & (fault | CH_OVERTEMP | THERM_LATCH));
    sequence settled_faults;
        $stable(fault) [*8];
    endsequence
    sequence settled_mux;
        ($stable(SENSE_SEL) && $stable(BYPASS_CMP)) [*8];
    endsequence
    therm_sets_a: assert property ($stable(CH_OVERTEMP) [*8] |-> (THERM_LATCH & CH_OVERTEMP) == CH_OVERTEMP)
        else $error("thermal latch missed a hot channel");
    gate_off_a: assert property ((GATE_EN & $past(THERM_LATCH)) == 6'h00)
        else $error("gate enabled on a latched channel");
    err_therm_a: assert property ($rose(|THERM_LATCH) && CS_N |-> ##[0:2] (ERR_FLAG & THERM_LATCH) == THERM_LATCH)
        else $error("thermal state missing from error flag");
    err_hold_a: assert property (CS_N && $past(CS_N) |-> (ERR_FLAG & $past(ERR_FLAG)) == $past(ERR_FLAG))
        else $error("error flag dropped outside a frame");
    ov_sets_a: assert property (settled_faults |-> (ERR_FLAG & fault) == fault)
        else $error("live overload not flagged");
    bypass_sel_a: assert property (settled_mux |-> BYPASS_RESULT == |(sel_hit & BYPASS_CMP))
        else $error("bypass bit not from selected channel");
    sense_fault_a: assert property (sel_bad [*6] |-> !SENSE_EN)
        else $error("sense on for a faulted channel");
    sense_on_a: assert property (sel_quiet [*8] |-> SENSE_EN)
        else $error("sense off for a healthy selected channel");
    sense_off_a: assert property (!sel_ok [*2] |-> !SENSE_EN)
        else $error("sense on with no channel selected");
    oe_idle_a: assert property (CS_N [*8] |-> !MISO_OE)
        else $error("miso driven while deselected");
endmodule // cfsd_top_props

/* tb/cfsd_spi_host.sv */
// spi host model sending 8-bit frames, msb first
// assumes one caller at a time; sclk idles low outside frames
`timescale 1ns/1ps
module cfsd_spi_host (
    input wire clk, // time base
    output reg sclk, // serial clock
    output reg cs_n, // select, active low
    output reg mosi, // data to block
    input wire miso // data from block
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // short high phase leaves the low phase longer than the miso shift delay
    task xfer(input [7:0] tx, output [7:0] rx);
        integer i;
        begin
            rx = 8'h00;
            @(negedge clk);
            cs_n = 1'b0;
            repeat (4) @(negedge clk);
            for (i = 7; i >= 0; i = i - 1) begin
                mosi = tx[i];
                repeat (6) @(negedge clk);
                sclk = 1'b1;
                rx = {rx[6:0], miso};
                repeat (2) @(negedge clk);
                sclk = 1'b0;
            end
            repeat (6) @(negedge clk);
            cs_n = 1'b1;
            mosi = ~mosi; // released line must not look like held data
            repeat (12) @(negedge clk);
        end
    endtask
endmodule // cfsd_spi_host

/* tb/tb_cfsd_top.sv */
// self-checking bench for the channel flag block
// assumes design, checker and host model compiled before this file
`timescale 1ns/1ps
module tb_cfsd_top;
    localparam [2:0] MUX_OFF_CODE = 3'h6;
    reg CLOCK;
    reg RST;
    reg [5:0] CH_ON, CH_OVERLOAD, CH_DYN_SHUT, CH_OVERTEMP, BYPASS_CMP;
    wire SCLK, CS_N, MOSI, MISO, MISO_OE, SENSE_EN, BYPASS_RESULT;
    wire [5:0] GATE_EN, ERR_FLAG, THERM_LATCH;
    wire [2:0] SENSE_SEL, LOAD_TYPE;
    integer n_mismatch = 0;
    integer checked = 0;
    integer k;
    reg [7:0] rx;
    cfsd_top #(.MUX_OFF_CODE(MUX_OFF_CODE)) dut_u (.CLOCK(CLOCK), .RST(RST), .SCLK(SCLK),
        .CS_N(CS_N), .MOSI(MOSI), .MISO(MISO), .MISO_OE(MISO_OE), .CH_ON(CH_ON),
        .CH_OVERLOAD(CH_OVERLOAD), .CH_DYN_SHUT(CH_DYN_SHUT), .CH_OVERTEMP(CH_OVERTEMP),
        .BYPASS_CMP(BYPASS_CMP), .GATE_EN(GATE_EN), .ERR_FLAG(ERR_FLAG),
        .THERM_LATCH(THERM_LATCH), .SENSE_SEL(SENSE_SEL), .SENSE_EN(SENSE_EN),
        .LOAD_TYPE(LOAD_TYPE), .BYPASS_RESULT(BYPASS_RESULT));
    cfsd_spi_host host_u (.clk(CLOCK), .sclk(SCLK), .cs_n(CS_N), .mosi(MOSI), .miso(MISO));
    initial begin
        CLOCK = 1'b0;
        forever #50 CLOCK = ~CLOCK;
    end
    task chk(input string what, input [7:0] seen, input [7:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("[ERR] %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task wait_clk(input integer n);
        repeat (n) @(negedge CLOCK);
    endtask
    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", checked, n_mismatch);
            if (n_mismatch == 0 && checked > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    task t_reset;
        begin
            chk("err", {2'h0, ERR_FLAG}, 8'h00);
            chk("sel", {5'h00, SENSE_SEL}, {5'h00, MUX_OFF_CODE});
            chk("sense", {7'h00, SENSE_EN}, 8'h00);
            chk("load", {5'h00, LOAD_TYPE}, 8'h00);
        end
    endtask
    task t_thermal;
        begin
            CH_ON = 6'h3f;
            CH_OVERTEMP = 6'h02;
            wait_clk(10);
            CH_OVERTEMP = 6'h00;
            wait_clk(10);
            chk("latch", {2'h0, THERM_LATCH}, 8'h02);
            chk("gate", {2'h0, GATE_EN}, 8'h3d);
            chk("err", {2'h0, ERR_FLAG}, 8'h02);
            host_u.xfer(8'h80, rx);
            chk("diag", rx, 8'h02);
            host_u.xfer(8'hc0, rx);
            chk("latch", {2'h0, THERM_LATCH}, 8'h02);
            host_u.xfer(8'hc1, rx);
            chk("gate", {2'h0, GATE_EN}, 8'h3f);
            host_u.xfer(8'h80, rx);
            chk("diag", rx, 8'h02);
            chk("err", {2'h0, ERR_FLAG}, 8'h00);
        end
    endtask
    task t_overload;
        begin
            CH_OVERLOAD = 6'h08;
            wait_clk(10);
            CH_OVERLOAD = 6'h00;
            wait_clk(20);
            chk("err", {2'h0, ERR_FLAG}, 8'h08);
            host_u.xfer(8'h80, rx);
            chk("diag", rx, 8'h08);
            chk("err", {2'h0, ERR_FLAG}, 8'h00);
            CH_OVERLOAD = 6'h01;
            CH_DYN_SHUT = 6'h10;
            wait_clk(10);
            host_u.xfer(8'h80, rx);
            chk("err", {2'h0, ERR_FLAG}, 8'h11);
            CH_OVERLOAD = 6'h00;
            CH_DYN_SHUT = 6'h00;
            wait_clk(10);
            host_u.xfer(8'h80, rx);
            chk("diag", rx, 8'h11);
            chk("err", {2'h0, ERR_FLAG}, 8'h00);
        end
    endtask
    task t_mux;
        begin
            host_u.xfer(8'ha5, rx);
            chk("load", {5'h00, LOAD_TYPE}, 8'h05);
            host_u.xfer(8'h82, rx);
            host_u.xfer(8'h80, rx);
            chk("load rd", rx, 8'h05);
            BYPASS_CMP = 6'h2a;
            for (k = 0; k < 6; k = k + 1) begin
                host_u.xfer(8'he0 | k[7:0], rx);
                host_u.xfer(8'h80, rx);
                chk("sbm", rx, {1'b0, BYPASS_CMP[k], 6'h00});
                chk("sense", {7'h00, SENSE_EN}, 8'h01);
                chk("sel", {5'h00, SENSE_SEL}, k[7:0]);
            end
            host_u.xfer(8'he1, rx);
            CH_OVERLOAD = 6'h02;
            wait_clk(10);
            chk("sense", {7'h00, SENSE_EN}, 8'h00);
            CH_OVERLOAD = 6'h00;
            host_u.xfer(8'he0 | {5'h00, MUX_OFF_CODE}, rx);
            chk("sense", {7'h00, SENSE_EN}, 8'h00);
            chk("sbm", {7'h00, BYPASS_RESULT}, 8'h00);
            host_u.xfer(8'h81, rx);
            host_u.xfer(8'h80, rx);
            chk("sel rd", rx, {5'h00, MUX_OFF_CODE});
        end
    endtask
    initial begin
        RST = 1'b1;
        CH_ON = 6'h00;
        CH_OVERLOAD = 6'h00;
        CH_DYN_SHUT = 6'h00;
        CH_OVERTEMP = 6'h00;
        BYPASS_CMP = 6'h00;
        wait_clk(2);
        RST = 1'b0;
        wait_clk(10);
        t_reset;
        t_thermal;
        t_overload;
        t_mux;
        end_of_test;
    end
endmodule // tb_cfsd_top
bind cfsd_top cfsd_top_props #(.MUX_OFF_CODE(MUX_OFF_CODE)) props_u (.CLOCK(CLOCK), .RST(RST),
    .CS_N(CS_N), .MISO_OE(MISO_OE), .CH_OVERLOAD(CH_OVERLOAD), .CH_DYN_SHUT(CH_DYN_SHUT),
    .CH_OVERTEMP(CH_OVERTEMP), .BYPASS_CMP(BYPASS_CMP), .GATE_EN(GATE_EN), .ERR_FLAG(ERR_FLAG),
    .THERM_LATCH(THERM_LATCH), .SENSE_SEL(SENSE_SEL), .SENSE_EN(SENSE_EN),
    .BYPASS_RESULT(BYPASS_RESULT));
